// >>> src/tlm_pkg.sv
// Purpose: Constants, types and decoders of the temperature limit monitor
// Assumes: Temperatures in signed tenths of a degree Celsius
// Notes:   Register offsets are byte addresses of 32-bit words
package tlm_pkg;

	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam logic [7:0]  ADDR_CFG0     = 8'h00;
	localparam logic [7:0]  ADDR_CFG1     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS   = 8'h08;
	localparam logic [7:0]  ADDR_INT_STAT = 8'h0C;
	localparam logic [7:0]  ADDR_INT_MASK = 8'h10;

	localparam int          CFG_SENSOR_BIT = 0;
	localparam int          CFG_BOTH_BIT   = 1;
	localparam int          CFG_CHG_BIT    = 2;
	localparam int          CFG_MODE_LSB   = 4;
	localparam int          CFG_THR_LSB    = 8;
	localparam int          CFG_HYS_LSB    = 16;
	localparam int          CFG_ON_LSB     = 20;
	localparam int          CFG_OFF_LSB    = 24;
	localparam int          CFG_CYC_LSB    = 0;
	localparam logic [31:0] CFG0_RST       = 32'h0000_0000;
	localparam logic [31:0] CFG1_RST       = 32'h0000_0000;

	localparam int          INT_W       = 2;
	localparam int          INT_TX_BIT  = 0;
	localparam int          INT_CHG_BIT = 1;

	localparam int          CLK_HZ          = 40_000_000;
	localparam int          TICK_MS         = 1000;
	localparam int          TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam logic [10:0] CYCLE_STEP_S    = 11'h00A;

	typedef enum logic [1:0] {ACT_OFF, ACT_ON, ACT_NONE} act_t;
	typedef enum {COND_NONE, COND_PRIM, COND_SEC} cond_t;

	typedef struct packed {
		logic exceedFirst;
		act_t primAct;
		act_t secAct;
	} mode_t;

	typedef struct packed {
		logic valid;
		logic value;
		logic cyclic;
	} telegram_t;

	typedef struct packed {
		logic       sensorOn;
		logic       bothLimits;
		logic       sendOnChange;
		logic [3:0] mode;
		logic [5:0] thrSel;
		logic [3:0] hysSel;
		logic [3:0] onSel;
		logic [3:0] offSel;
		logic [6:0] cycSel;
	} cfg_t;

	// Steps -15,-10, then -5..35 by one, then 40,45,50
	function automatic logic signed [13:0] thrTenths(input logic [5:0] s);
		logic signed [13:0] i;
		logic signed [13:0] deg;
		i = $signed({8'h00, s});
		if (i < 14'sh0002)
			deg = i * 14'sh0005 - 14'sh000F;
		else if (i < 14'sh002B)
			deg = i - 14'sh0007;
		else if (i < 14'sh002E)
			deg = i * 14'sh0005 - 14'sh00AF;
		else
			deg = 14'sh0032;
		return deg * 14'sh000A;
	endfunction

	function automatic logic signed [13:0] hysTenths(input logic [3:0] s);
		logic signed [13:0] h;
		h = 14'sh0000;
		unique case (s)
			4'h6:    h = 14'sh0064;
			4'h7:    h = 14'sh0096;
			4'h8:    h = 14'sh00C8;
			default: h = (s > 4'h8) ? 14'sh00C8 :
				$signed({10'h000, s}) * 14'sh000A;
		endcase
		return h;
	endfunction

	function automatic logic [11:0] delaySec(input logic [3:0] s);
		logic [11:0] d;
		d = 12'h000;
		unique case (s)
			4'h0:    d = 12'h000;
			4'h1:    d = 12'h001;
			4'h2:    d = 12'h003;
			4'h3:    d = 12'h005;
			4'h4:    d = 12'h00A;
			4'h5:    d = 12'h00F;
			4'h6:    d = 12'h01E;
			4'h7:    d = 12'h03C;
			4'h8:    d = 12'h0B4;
			4'h9:    d = 12'h12C;
			4'hA:    d = 12'h258;
			4'hB:    d = 12'h384;
			4'hC:    d = 12'h708;
			default: d = 12'hE10;
		endcase
		return d;
	endfunction

	function automatic mode_t modeDecode(input logic [3:0] m);
		mode_t r;
		r = '{1'b1, ACT_ON, ACT_OFF};
		unique case (m)
			4'h0:    r = '{1'b1, ACT_ON, ACT_OFF};
			4'h1:    r = '{1'b1, ACT_OFF, ACT_ON};
			4'h2:    r = '{1'b0, ACT_ON, ACT_OFF};
			4'h3:    r = '{1'b0, ACT_OFF, ACT_ON};
			4'h4:    r = '{1'b1, ACT_ON, ACT_NONE};
			4'h5:    r = '{1'b1, ACT_OFF, ACT_NONE};
			4'h6:    r = '{1'b0, ACT_ON, ACT_NONE};
			4'h7:    r = '{1'b0, ACT_OFF, ACT_NONE};
			4'h8:    r = '{1'b1, ACT_NONE, ACT_OFF};
			4'h9:    r = '{1'b1, ACT_NONE, ACT_ON};
			4'hA:    r = '{1'b0, ACT_NONE, ACT_OFF};
			4'hB:    r = '{1'b0, ACT_NONE, ACT_ON};
			default: r = '{1'b1, ACT_ON, ACT_OFF};
		endcase
		return r;
	endfunction

endpackage

// >>> src/temperature_limit_monitor.sv
// Purpose: Second temperature limit channel with delays and bus telegrams
// Assumes: tempValid pulses with each new measurement in tenths of degC
// Notes:   Timers step on a one-second tick from the system clock
//
// Overview of operation
// [R01] Object goes to 1 only after the full switch-on delay.
// [R02] Cyclic telegrams keep sending 0 while switch-on delay runs.
// [R03] Switch-off delay selectable from none up to 60 minutes.
// [R04] Object goes to 0 only after the full switch-off delay.
// [R05] Cyclic telegrams keep sending 1 while switch-off delay runs.
// [R06] Condition set to no telegram also suppresses cyclic sends.
// [R07] Send on change sends every 0-to-1 and 1-to-0 change.
// [R08] Cyclic setting of one or more sends periodically regardless.
// [R09] Cyclic period is setting times ten seconds.
// [R10] Cyclic setting zero disables periodic sending.
// [R11] No change sending and cyclic zero means nothing is sent.
// [R12] Channel works only with sensor on and both limits selected.
// [R13] Threshold chosen from fixed steps, -15 to +50 degC.
// [R14] Hysteresis chosen from none, 1-5, 10, 15 or 20 K.
// [R15] Threshold, hysteresis and mode decide set or clear.
// [R16] Mode picks ON, OFF or no telegram for each crossing.
// [R17] Switch-on delay selectable from none up to 60 minutes.
// [R18] Reset clears state, object and timers; timers use 1 s tick.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module temperature_limit_monitor
	import tlm_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int TEMP_W      = 12
) (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic [ADDR_W-1:0]        addr,
	input  wire logic [DATA_W-1:0]        wrData,
	input  wire logic                     wrStrobe,
	input  wire logic                     rdStrobe,
	output logic      [DATA_W-1:0]        rdData,
	input  wire logic signed [TEMP_W-1:0] tempValue,
	input  wire logic                     tempValid,
	output telegram_t                     txTelegram,
	output logic                          irq
);

	localparam int TICK_W = $clog2(TICK_CYCLES);

	cfg_t              cfg;
	logic [INT_W-1:0]  intStat;
	logic [INT_W-1:0]  intMask;
	logic [TICK_W-1:0] tickCount;
	logic              secTick;
	cond_t             cond;
	cond_t             next_cond;
	logic              rawState;
	logic              next_rawState;
	logic              object;
	logic [11:0]       dlyCount;
	logic [10:0]       cycCount;

	logic               active;
	mode_t              md;
	logic signed [13:0] tempExt;
	logic signed [13:0] thr;
	logic signed [13:0] hys;
	logic               primHit;
	logic               secHit;
	logic               pending;
	logic [11:0]        dlyLimit;
	logic               accept;
	logic [10:0]        cycPeriod;
	logic               cycFire;
	logic               suppress;
	logic               chgSend;
	logic               cycSend;
	logic [INT_W-1:0]   events;
	logic [INT_W-1:0]   intClr;

	assign active = cfg.sensorOn & cfg.bothLimits; // [R12]
	assign md     = modeDecode(cfg.mode); // [R16]

	// One-second timebase
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tickCount <= '0;
			secTick   <= 1'b0;
		end else if (tickCount == TICK_W'(TICK_CYCLES - 1)) begin
			tickCount <= '0;
			secTick   <= 1'b1; // [R18]
		end else begin
			tickCount <= tickCount + 1'b1;
			secTick   <= 1'b0;
		end
	end

	// Threshold crossings
	always_comb begin
		tempExt = 14'(tempValue);
		thr     = thrTenths(cfg.thrSel); // [R13]
		hys     = hysTenths(cfg.hysSel); // [R14]
		if (md.exceedFirst) begin
			primHit = tempExt > thr; // [R15]
			secHit  = tempExt < thr - hys;
		end else begin
			primHit = tempExt < thr;
			secHit  = tempExt > thr + hys;
		end
	end

	always_comb begin
		next_cond     = cond;
		next_rawState = rawState;
		if (tempValid) begin
			if (primHit)
				next_cond = COND_PRIM;
			else if (secHit)
				next_cond = COND_SEC;
		end
		if (next_cond != cond) begin
			if (next_cond == COND_PRIM && md.primAct != ACT_NONE)
				next_rawState = (md.primAct == ACT_ON); // [R16]
			else if (next_cond == COND_SEC && md.secAct != ACT_NONE)
				next_rawState = (md.secAct == ACT_ON); // [R16]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n || !active) begin
			cond     <= COND_NONE; // [R18]
			rawState <= 1'b0;
		end else begin
			cond     <= next_cond;
			rawState <= next_rawState; // [R15]
		end
	end

	// Switch-on and switch-off delays
	assign pending  = rawState != object;
	assign dlyLimit = rawState ? delaySec(cfg.onSel) // [R17]
		: delaySec(cfg.offSel); // [R03]
	// One tick beyond the setting, as the first second may be partial
	assign accept   = active && pending
		&& (dlyCount > dlyLimit || dlyLimit == 12'h000); // [R01] [R04]

	always_ff @(posedge clk) begin
		if (!reset_n || !pending || accept)
			dlyCount <= '0;
		else if (secTick)
			dlyCount <= dlyCount + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n || !active)
			object <= 1'b0; // [R18]
		else if (accept)
			object <= rawState; // [R01] [R04]
	end

	// Cyclic repetition
	assign cycPeriod = {4'h0, cfg.cycSel} * CYCLE_STEP_S; // [R09]
	assign cycFire   = secTick && cfg.cycSel != 7'h00 // [R08] [R10]
		&& cycCount >= cycPeriod - 11'h001;
	assign suppress  = (cond == COND_PRIM && md.primAct == ACT_NONE)
		|| (cond == COND_SEC && md.secAct == ACT_NONE);

	always_ff @(posedge clk) begin
		if (!reset_n || !active || cfg.cycSel == 7'h00)
			cycCount <= '0; // [R10]
		// New cycle setting starts a fresh period
		else if (wrStrobe && addr == ADDR_CFG1)
			cycCount <= '0;
		else if (cycFire)
			cycCount <= '0;
		else if (secTick)
			cycCount <= cycCount + 11'h001;
	end

	// Telegram generation
	assign chgSend = accept && cfg.sendOnChange; // [R07]
	assign cycSend = cycFire && !suppress && active; // [R06]

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			txTelegram <= '0;
		end else begin
			txTelegram.valid  <= chgSend | cycSend; // [R11]
			// Old object value goes out while a delay runs
			txTelegram.value  <= accept ? rawState : object; // [R02] [R05]
			txTelegram.cyclic <= cycSend & ~chgSend;
		end
	end

	// Register file
	assign intClr = (wrStrobe && addr == ADDR_INT_STAT)
		? wrData[INT_W-1:0] : '0;

	always_comb begin
		events              = '0;
		events[INT_TX_BIT]  = chgSend | cycSend;
		events[INT_CHG_BIT] = accept;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg.sensorOn     <= CFG0_RST[CFG_SENSOR_BIT];
			cfg.bothLimits   <= CFG0_RST[CFG_BOTH_BIT];
			cfg.sendOnChange <= CFG0_RST[CFG_CHG_BIT];
			cfg.mode         <= CFG0_RST[CFG_MODE_LSB +: 4];
			cfg.thrSel       <= CFG0_RST[CFG_THR_LSB +: 6];
			cfg.hysSel       <= CFG0_RST[CFG_HYS_LSB +: 4];
			cfg.onSel        <= CFG0_RST[CFG_ON_LSB +: 4];
			cfg.offSel       <= CFG0_RST[CFG_OFF_LSB +: 4];
			cfg.cycSel       <= CFG1_RST[CFG_CYC_LSB +: 7];
			intMask <= '0;
		end else if (wrStrobe) begin
			if (addr == ADDR_CFG0) begin
				cfg.sensorOn     <= wrData[CFG_SENSOR_BIT];
				cfg.bothLimits   <= wrData[CFG_BOTH_BIT];
				cfg.sendOnChange <= wrData[CFG_CHG_BIT];
				cfg.mode         <= wrData[CFG_MODE_LSB +: 4];
				cfg.thrSel       <= wrData[CFG_THR_LSB +: 6];
				cfg.hysSel       <= wrData[CFG_HYS_LSB +: 4];
				cfg.onSel        <= wrData[CFG_ON_LSB +: 4];
				cfg.offSel       <= wrData[CFG_OFF_LSB +: 4];
			end
			if (addr == ADDR_CFG1)
				cfg.cycSel <= wrData[CFG_CYC_LSB +: 7];
			if (addr == ADDR_INT_MASK)
				intMask <= wrData[INT_W-1:0];
		end
	end

	// Sticky events win over a same-cycle clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			intStat <= '0;
			irq     <= 1'b0;
		end else begin
			intStat <= (intStat & ~intClr) | events;
			irq     <= |(((intStat & ~intClr) | events) & intMask);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdData <= '0;
		end else if (rdStrobe) begin
			unique case (addr)
				ADDR_CFG0: rdData <= {4'h0, cfg.offSel, cfg.onSel,
					cfg.hysSel, 2'b00, cfg.thrSel, cfg.mode, 1'b0,
					cfg.sendOnChange, cfg.bothLimits, cfg.sensorOn};
				ADDR_CFG1:     rdData <= {25'h000_0000, cfg.cycSel};
				ADDR_STATUS:   rdData <= {26'h000_0000,
					cond == COND_SEC, cond == COND_PRIM,
					pending & ~rawState, pending & rawState,
					object, rawState};
				ADDR_INT_STAT: rdData <= {30'h0000_0000, intStat};
				ADDR_INT_MASK: rdData <= {30'h0000_0000, intMask};
				default:       rdData <= '0;
			endcase
		end else begin
			rdData <= '0;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence objRise;
		!object ##1 object;
	endsequence

	sequence objFall;
		object && active ##1 !object;
	endsequence

	AST_ON_DELAY: assert property ( // [R01]
		objRise |-> $past(rawState) && ($past(dlyCount)
			> $past(delaySec(cfg.onSel))
			|| $past(delaySec(cfg.onSel)) == 12'h000))
		else $error("object rose before switch-on delay");

	AST_OFF_DELAY: assert property ( // [R04]
		objFall |-> $past(dlyCount) > $past(delaySec(cfg.offSel))
			|| $past(delaySec(cfg.offSel)) == 12'h000)
		else $error("object fell before switch-off delay");

	AST_CYC_OLD_ZERO: assert property ( // [R02]
		cycSend && !accept && rawState && !object
			|=> txTelegram.valid && !txTelegram.value)
		else $error("cyclic send during on delay not zero");

	AST_CYC_OLD_ONE: assert property ( // [R05]
		cycSend && !accept && !rawState && object
			|=> txTelegram.valid && txTelegram.value)
		else $error("cyclic send during off delay not one");

	AST_NO_CYC_SUPPRESS: assert property ( // [R06]
		suppress && !accept |=> !txTelegram.valid)
		else $error("cyclic telegram not suppressed");

	AST_CHG_SEND: assert property ( // [R07]
		accept && cfg.sendOnChange |=> txTelegram.valid
			&& txTelegram.value == object)
		else $error("change not sent");

	AST_NO_CHG_SEND: assert property ( // [R07]
		accept && !cfg.sendOnChange && !cycFire |=> !txTelegram.valid)
		else $error("change sent while disabled");

	AST_CYC_BOUND: assert property ( // [R09]
		cfg.cycSel != 7'h00 |-> cycCount < cycPeriod)
		else $error("cycle counter beyond period");

	AST_CYC_ZERO: assert property ( // [R10]
		cfg.cycSel == 7'h00 ##1 cfg.cycSel == 7'h00
			|-> cycCount == 11'h000 && !cycFire)
		else $error("cyclic active with setting zero");

	AST_SILENT: assert property ( // [R11]
		!cfg.sendOnChange && cfg.cycSel == 7'h00 |=> !txTelegram.valid)
		else $error("telegram sent while sending disabled");

	AST_INACTIVE: assert property ( // [R12]
		!active |=> !object && !rawState ##1 !txTelegram.valid)
		else $error("channel acts while inactive");

	AST_TICK: assert property ( // [R18]
		secTick |=> !secTick [*2])
		else $error("second tick too frequent");

	AST_RESET_CLEAR: assert property (disable iff (1'b0) // [R18]
		!reset_n |=> !object && !rawState && dlyCount == 12'h000
			&& cycCount == 11'h000 && !txTelegram.valid)
		else $error("state not cleared by reset");

	AST_HOLD_OBJECT: assert property ( // [R01] [R04]
		active && !accept |=> $stable(object))
		else $error("object changed without delay expiry");

	AST_THR_RANGE: assert property ( // [R13]
		thr >= -14'sh0096 && thr <= 14'sh01F4)
		else $error("threshold outside step range");

	AST_HYS_RANGE: assert property ( // [R14]
		hys >= 14'sh0000 && hys <= 14'sh00C8)
		else $error("hysteresis outside step range");

endmodule

// >>> tb/bus_listener.sv
// Purpose: Bus participant that listens to limit object telegrams
// Assumes: One telegram per valid pulse on txTelegram
// Notes:   Keeps counts, last value and spacing of cyclic telegrams
`timescale 1ns/1ps

module bus_listener
	import tlm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire telegram_t  txTelegram,
	output logic     [15:0] count,
	output logic            lastValue,
	output logic            lastCyclic,
	output logic     [15:0] cycGap
);
	logic [15:0] now;
	logic [15:0] lastCyc;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			now        <= 16'h0000;
			count      <= 16'h0000;
			lastValue  <= 1'b0;
			lastCyclic <= 1'b0;
			cycGap     <= 16'h0000;
			lastCyc    <= 16'h0000;
		end else begin
			now <= now + 16'h0001;
			if (txTelegram.valid) begin
				count      <= count + 16'h0001;
				lastValue  <= txTelegram.value;
				lastCyclic <= txTelegram.cyclic;
				// Spacing between cyclic telegrams, in clock cycles
				if (txTelegram.cyclic) begin
					cycGap  <= now - lastCyc;
					lastCyc <= now;
				end
			end
		end
	end
endmodule

// >>> tb/temperature_limit_monitor_bench.sv
// Purpose: Self-checking bench of the temperature limit monitor
// Assumes: One second is shortened to 8 clock cycles
// Notes:   Register tasks follow the one-cycle strobe protocol
`timescale 1ns/1ps

module temperature_limit_monitor_bench
	import tlm_pkg::*;
;
	localparam int TK = 8;
	logic             clk;
	logic             reset_n;
	logic [7:0]       addr;
	logic [31:0]      wrData;
	logic             wrStrobe;
	logic             rdStrobe;
	logic [31:0]      rdData;
	logic signed [11:0] tempValue;
	logic             tempValid;
	telegram_t        txTelegram;
	logic             irq;
	logic [15:0]      count;
	logic             lastValue;
	logic             lastCyclic;
	logic [15:0]      cycGap;
	int               fails;
	int               totalChecks;
	logic [15:0]      c0;

	temperature_limit_monitor #(.TICK_CYCLES(TK), .TEMP_W(12)) dut (
		.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
		.tempValue(tempValue), .tempValid(tempValid),
		.txTelegram(txTelegram), .irq(irq));

	bus_listener listener (
		.clk(clk), .reset_n(reset_n), .txTelegram(txTelegram),
		.count(count), .lastValue(lastValue), .lastCyclic(lastCyclic),
		.cycGap(cycGap));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		totalChecks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic completeRun();
		$display("Checks %0d, mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr     <= a;
		wrData   <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd(input string nm, input logic [7:0] a,
			input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		addr     <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		chk(nm, e, rdData & m);
	endtask

	task automatic sample(input logic signed [11:0] v);
		@(posedge clk);
		tempValue <= v;
		tempValid <= 1'b1;
		@(posedge clk);
		tempValid <= 1'b0;
	endtask

	// Waits for the next telegram, a missing one counts as a mismatch
	task automatic waitTx(input int lim);
		int n;
		logic [15:0] s;
		s = count;
		n = 0;
		while (count === s && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("telegram seen", 32'h0000_0001, {31'h0, count !== s});
	endtask

	initial begin
		fails = 0;
		totalChecks = 0;
		addr = 8'h00;
		wrData = 32'h0000_0000;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		tempValue = 12'sh000;
		tempValid = 1'b0;
		reset_n = 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		rd("cfg0", ADDR_CFG0, 32'hFFFF_FFFF, CFG0_RST);
		rd("cfg1", ADDR_CFG1, 32'hFFFF_FFFF, CFG1_RST);
		rd("status", ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
		rd("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("Test reset done");
		// Threshold 20 degC, hysteresis 2 K, on 1 s, off 3 s
		wr(ADDR_CFG0, 32'h0212_1B05);
		sample(12'sd300);
		rd("inactive", ADDR_STATUS, 32'h0000_0003, 32'h0000_0000);
		wr(ADDR_CFG0, 32'h0212_1B07);
		sample(12'sd300);
		rd("on pending", ADDR_STATUS, 32'h0000_0003, 32'h0000_0001);
		waitTx(4 * TK);
		chk("on value", 32'h1, {31'h0, lastValue});
		chk("on chg flag", 32'h0, {31'h0, lastCyclic});
		sample(12'sd190);
		rd("in hyst", ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
		sample(12'sd170);
		repeat (2 * TK) @(posedge clk);
		rd("off pending", ADDR_STATUS, 32'h0000_0003, 32'h0000_0002);
		waitTx(4 * TK);
		chk("off value", 32'h0, {31'h0, lastValue});
		$display("Test delays done");
		// On delay 60 s, cyclic every 10 s, no change sending
		wr(ADDR_CFG0, 32'h0572_1B03);
		wr(ADDR_CFG1, 32'h0000_0001);
		sample(12'sd300);
		waitTx(12 * TK);
		waitTx(12 * TK);
		chk("cyc gap", 32'd80, {16'h0, cycGap});
		chk("cyc flag", 32'h1, {31'h0, lastCyclic});
		chk("cyc old", 32'h0, {31'h0, lastValue});
		repeat (6) waitTx(12 * TK);
		chk("cyc new", 32'h1, {31'h0, lastValue});
		sample(12'sd100);
		waitTx(12 * TK);
		chk("cyc old one", 32'h1, {31'h0, lastValue});
		$display("Test cyclic done");
		// Secondary crossing gives no telegram
		wr(ADDR_CFG0, 32'h0200_1B43);
		sample(12'sd300);
		sample(12'sd100);
		repeat (2) @(posedge clk);
		c0 = count;
		repeat (25 * TK) @(posedge clk);
		chk("muted cyc", {16'h0, c0}, {16'h0, count});
		rd("muted raw", ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
		$display("Test muted done");
		wr(ADDR_CFG1, 32'h0000_0000);
		wr(ADDR_CFG0, 32'h0200_1B03);
		c0 = count;
		sample(12'sd300);
		repeat (6 * TK) @(posedge clk);
		sample(12'sd100);
		repeat (15 * TK) @(posedge clk);
		chk("silent", {16'h0, c0}, {16'h0, count});
		rd("silent off", ADDR_STATUS, 32'h0000_0003, 32'h0000_0000);
		$display("Test silent done");
		wr(ADDR_CFG0, 32'h0000_1B07);
		wr(ADDR_INT_STAT, 32'h0000_0003);
		wr(ADDR_INT_MASK, 32'h0000_0001);
		sample(12'sd300);
		waitTx(3 * TK);
		repeat (2) @(posedge clk);
		#1;
		chk("irq on", 32'h1, {31'h0, irq});
		rd("int stat", ADDR_INT_STAT, 32'h0000_0003, 32'h0000_0003);
		wr(ADDR_INT_STAT, 32'h0000_0003);
		repeat (2) @(posedge clk);
		#1;
		chk("irq clr", 32'h0, {31'h0, irq});
		wr(ADDR_INT_MASK, 32'h0000_0000);
		sample(12'sd100);
		waitTx(3 * TK);
		repeat (2) @(posedge clk);
		#1;
		chk("irq masked", 32'h0, {31'h0, irq});
		rd("int set", ADDR_INT_STAT, 32'h0000_0003, 32'h0000_0003);
		$display("Test interrupt done");
		// Undershoot mode: below threshold ON, above plus 2 K OFF
		wr(ADDR_CFG0, 32'h0002_1B27);
		sample(12'sd100);
		waitTx(3 * TK);
		chk("under on", 32'h1, {31'h0, lastValue});
		sample(12'sd300);
		waitTx(3 * TK);
		chk("over off", 32'h0, {31'h0, lastValue});
		$display("Test undershoot done");
		completeRun();
	end

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		completeRun();
	end
endmodule
